// *** core/gpc_bank.sv ***
`timescale 1ns/1ps
// Contract
// RQ1: Bit 0 set makes the pin an input, clear an output; default 0x01.
// RQ2: Bit 1 set inverts the pin's logical sense.
// RQ3: Bit 2 set selects the alternate function; bits 6:3 reserved.
// RQ4: Bit 7 set selects open-drain driver, clear push-pull.
// RQ5: Index 0x30 configures pin 2.5; alternate is music serial receive.
// RQ6: Index 0x31 configures pin 2.6; alternate is music serial transmit.
// RQ7: Index 0x32 configures pin 2.7; alternate is active-low system-management interrupt.
// RQ8: Index 0x33 configures pin 3.0; alternate is fan speed sense 2.
// RQ9: Index 0x34 configures pin 3.1; alternate is fan speed sense 1.
// RQ10: Index 0x35 pin 3.2, fan drive 2; 0x01 standby, 0x00 main reset.
// RQ11: Index 0x36 pin 3.3, fan drive 1; 0x01 standby, 0x00 main reset.
// RQ12: Index 0x37 pin 3.4, infrared receive 2; resets to 0x05.
// RQ13: Index 0x38 pin 3.5, infrared transmit 2; 0x04 on every reset.
// RQ14: Index 0x39 pin 3.6; alternate is active-low keyboard reset.
// RQ15: Reserved bits 6:3 ignore writes and read as zero.
module gpc_bank
  import gpc_pkg::*;
#(
  parameter int unsigned NPINS = GPC_NUM_PINS
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             main_rst_i,
  // Wishbone classic slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [9:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Pads
  input  wire logic [NPINS-1:0] pin_i,
  output logic      [NPINS-1:0] pin_o,
  output logic      [NPINS-1:0] pin_oe_n_o,
  // Plain general-purpose data
  input  wire logic [NPINS-1:0] gp_out_i,
  output logic      [NPINS-1:0] gp_in_o,
  // Alternate-function peripherals
  output logic                  music_serial_rx_o,
  input  wire logic             music_serial_tx_i,
  input  wire logic             sys_mgmt_irq_n_i,
  output logic                  fan_speed_sense_2_o,
  output logic                  fan_speed_sense_1_o,
  input  wire logic             fan_drive_2_i,
  input  wire logic             fan_drive_1_i,
  output logic                  infrared_rx_2_o,
  input  wire logic             infrared_tx_2_i,
  input  wire logic             keyboard_reset_n_i
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NPINS-1:0][7:0] cfg;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  main_rst_en;
  } gpc_state_s;

  gpc_state_s st_ff;
  gpc_state_s nxt_st;

  logic [NPINS-1:0] alt_out;
  logic [NPINS-1:0] alt_is_out;
  logic [NPINS-1:0] alt_in;
  logic [7:0]       idx;
  logic             hit_cfg;
  logic [3:0]       sel_pin;
  logic             req;

  function automatic logic [7:0] stby_default(input int unsigned p);
    case (p)
      GPC_PIN_P34: stby_default = GPC_RST_P34;  // [RQ12]
      GPC_PIN_P35: stby_default = GPC_RST_P35;  // [RQ13]
      default:     stby_default = GPC_RST_STBY; // [RQ1] [RQ10] [RQ11]
    endcase
  endfunction

  // ----------------------------------------
  // Register access and main-supply reset
  // ----------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    idx      = adr_i[9:2];
    hit_cfg  = (idx >= GPC_IDX_FIRST) && (idx <= GPC_IDX_LAST);
    sel_pin  = 4'(idx - GPC_IDX_FIRST);
    req      = cyc_i && stb_i && !st_ff.ack;
    nxt_st.ack = req;
    if (req) begin
      nxt_st.rdat = 32'h0000_0000;
      if (hit_cfg) begin
        // Reserved bits are never stored, so they read as zero
        nxt_st.rdat[7:0] = st_ff.cfg[sel_pin];                              // [RQ15]
        if (we_i && sel_i[0]) begin
          nxt_st.cfg[sel_pin] = dat_i[7:0] & GPC_WR_MASK;                   // [RQ15]
        end
      end else if (idx == GPC_IDX_RST_CTRL) begin
        nxt_st.rdat[0] = st_ff.main_rst_en;
        if (we_i && sel_i[0]) begin
          nxt_st.main_rst_en = dat_i[0];
        end
      end
    end
    // Main-supply power-on or hard reset
    if (main_rst_i && st_ff.main_rst_en) begin
      nxt_st.cfg[GPC_PIN_P32] = GPC_RST_MAIN_FAN;                           // [RQ10]
      nxt_st.cfg[GPC_PIN_P33] = GPC_RST_MAIN_FAN;                           // [RQ11]
      nxt_st.cfg[GPC_PIN_P35] = GPC_RST_P35;                                // [RQ13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NPINS; p++) begin
        st_ff.cfg[p] <= stby_default(p);                                    // [RQ1]
      end
      st_ff.ack         <= 1'b0;
      st_ff.rdat        <= 32'h0000_0000;
      st_ff.main_rst_en <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ack_o = st_ff.ack;
  assign dat_o = st_ff.rdat;

  // ----------------------------------------
  // Alternate-function routing
  // ----------------------------------------
  always_comb begin
    alt_out    = '0;
    alt_is_out = '0;
    alt_out[GPC_PIN_P26]    = music_serial_tx_i;                            // [RQ6]
    alt_is_out[GPC_PIN_P26] = 1'b1;
    alt_out[GPC_PIN_P27]    = sys_mgmt_irq_n_i;                             // [RQ7]
    alt_is_out[GPC_PIN_P27] = 1'b1;
    alt_out[GPC_PIN_P32]    = fan_drive_2_i;                                // [RQ10]
    alt_is_out[GPC_PIN_P32] = 1'b1;
    alt_out[GPC_PIN_P33]    = fan_drive_1_i;                                // [RQ11]
    alt_is_out[GPC_PIN_P33] = 1'b1;
    alt_out[GPC_PIN_P35]    = infrared_tx_2_i;                              // [RQ13]
    alt_is_out[GPC_PIN_P35] = 1'b1;
    alt_out[GPC_PIN_P36]    = keyboard_reset_n_i;                           // [RQ14]
    alt_is_out[GPC_PIN_P36] = 1'b1;
  end

  for (genvar g = 0; g < NPINS; g++) begin : g_pin
    gpc_pin_cell u_cell (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .cfg_i        (st_ff.cfg[g]),
      .pin_i        (pin_i[g]),
      .gp_out_i     (gp_out_i[g]),
      .alt_out_i    (alt_out[g]),
      .alt_is_out_i (alt_is_out[g]),
      .pin_o        (pin_o[g]),
      .pin_oe_n_o   (pin_oe_n_o[g]),
      .gp_in_o      (gp_in_o[g]),
      .alt_in_o     (alt_in[g])
    );
  end

  assign music_serial_rx_o   = alt_in[GPC_PIN_P25];                        // [RQ5]
  assign fan_speed_sense_2_o = alt_in[GPC_PIN_P30];                        // [RQ8]
  assign fan_speed_sense_1_o = alt_in[GPC_PIN_P31];                        // [RQ9]
  assign infrared_rx_2_o     = alt_in[GPC_PIN_P34];                        // [RQ12]

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[6:3] == 4'h0)  // [RQ15]
    else $error("reserved bits read nonzero");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held more than one cycle");
  a_write_stores: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && we_i && sel_i[0] && hit_cfg && !main_rst_i)
      |=> st_ff.cfg[$past(sel_pin)] == ($past(dat_i[7:0]) & 8'h87))  // [RQ15]
    else $error("config write not stored");
  a_fan_main_rst: assert property (@(posedge clk_i) disable iff (rst_i)
    (main_rst_i && st_ff.main_rst_en) |=> st_ff.cfg[GPC_PIN_P32] == 8'h00
      && st_ff.cfg[GPC_PIN_P33] == 8'h00 && st_ff.cfg[GPC_PIN_P35] == 8'h04)  // [RQ10]
    else $error("main reset default wrong");
  a_stby_defaults: assert property (@(posedge clk_i)
    !rst_i && $past(rst_i) |-> st_ff.cfg[GPC_PIN_P34] == 8'h05 && st_ff.cfg[GPC_PIN_P35] == 8'h04
      && st_ff.cfg[GPC_PIN_P25] == 8'h01)  // [RQ12]
    else $error("standby default wrong");
  a_irtx_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.cfg[GPC_PIN_P35] == 8'h04) |=> pin_oe_n_o[GPC_PIN_P35] == 1'b0
      && pin_o[GPC_PIN_P35] == $past(infrared_tx_2_i))  // [RQ13]
    else $error("infrared tx not routed");
  a_irrx_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.cfg[GPC_PIN_P34] == 8'h05) |=> infrared_rx_2_o == $past(pin_i[GPC_PIN_P34]))  // [RQ12]
    else $error("infrared rx not routed");
  a_kbd_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.cfg[GPC_PIN_P36] == 8'h06) |=> pin_o[GPC_PIN_P36] == !$past(keyboard_reset_n_i))  // [RQ14]
    else $error("keyboard reset not routed");

  c_write: cover property (@(posedge clk_i) cyc_i && stb_i && we_i && hit_cfg && ack_o);
  c_read: cover property (@(posedge clk_i) cyc_i && stb_i && !we_i && hit_cfg && ack_o);
  c_od_low: cover property (@(posedge clk_i) st_ff.cfg[0][7] && !pin_oe_n_o[0]);
  c_main_rst: cover property (@(posedge clk_i) main_rst_i && st_ff.main_rst_en);

endmodule

// *** core/gpc_pkg.sv ***
package gpc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned GPC_NUM_PINS = 10;
  // Printed offsets are not multiples of four: they are word indices
  localparam logic [7:0] GPC_IDX_FIRST = 8'h30;
  localparam logic [7:0] GPC_IDX_LAST  = 8'h39;
  localparam logic [7:0] GPC_IDX_P25   = 8'h30;
  localparam logic [7:0] GPC_IDX_P26   = 8'h31;
  localparam logic [7:0] GPC_IDX_P27   = 8'h32;
  localparam logic [7:0] GPC_IDX_P30   = 8'h33;
  localparam logic [7:0] GPC_IDX_P31   = 8'h34;
  localparam logic [7:0] GPC_IDX_P32   = 8'h35;
  localparam logic [7:0] GPC_IDX_P33   = 8'h36;
  localparam logic [7:0] GPC_IDX_P34   = 8'h37;
  localparam logic [7:0] GPC_IDX_P35   = 8'h38;
  localparam logic [7:0] GPC_IDX_P36   = 8'h39;
  // Added control register, word index
  localparam logic [7:0] GPC_IDX_RST_CTRL = 8'h3F;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned GPC_BIT_DIR   = 0;
  localparam int unsigned GPC_BIT_POL   = 1;
  localparam int unsigned GPC_BIT_ALT   = 2;
  localparam int unsigned GPC_BIT_OTYPE = 7;
  localparam logic [7:0] GPC_WR_MASK    = 8'h87;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] GPC_RST_STBY     = 8'h01;
  localparam logic [7:0] GPC_RST_MAIN_FAN = 8'h00;
  localparam logic [7:0] GPC_RST_P34      = 8'h05;
  localparam logic [7:0] GPC_RST_P35      = 8'h04;

  // Local pin index of each register
  localparam int unsigned GPC_PIN_P25 = 0;
  localparam int unsigned GPC_PIN_P26 = 1;
  localparam int unsigned GPC_PIN_P27 = 2;
  localparam int unsigned GPC_PIN_P30 = 3;
  localparam int unsigned GPC_PIN_P31 = 4;
  localparam int unsigned GPC_PIN_P32 = 5;
  localparam int unsigned GPC_PIN_P33 = 6;
  localparam int unsigned GPC_PIN_P34 = 7;
  localparam int unsigned GPC_PIN_P35 = 8;
  localparam int unsigned GPC_PIN_P36 = 9;

  typedef enum logic [1:0] {
    GPC_IDLE = 2'b00,
    GPC_ACK  = 2'b01
  } gpc_bus_e;

endpackage

// *** core/gpc_pin_cell.sv ***
`timescale 1ns/1ps
module gpc_pin_cell
  import gpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] cfg_i,
  input  wire logic       pin_i,
  input  wire logic       gp_out_i,
  input  wire logic       alt_out_i,
  input  wire logic       alt_is_out_i,
  output logic            pin_o,
  output logic            pin_oe_n_o,
  output logic            gp_in_o,
  output logic            alt_in_o
);

  // ----------------------------------------
  // Pad state
  // ----------------------------------------
  typedef struct packed {
    logic pin;
    logic oe_n;
    logic gp_in;
    logic alt_in;
  } gpc_cell_s;

  gpc_cell_s st_ff;
  gpc_cell_s nxt_st;

  logic is_out;
  logic dval;
  logic rx;

  always_comb begin
    nxt_st = st_ff;
    // Alternate output follows the peripheral direction, else bit 0
    is_out = cfg_i[GPC_BIT_ALT] ? alt_is_out_i : ~cfg_i[GPC_BIT_DIR];          // [RQ1] [RQ3]
    dval   = (cfg_i[GPC_BIT_ALT] ? alt_out_i : gp_out_i) ^ cfg_i[GPC_BIT_POL]; // [RQ2]
    rx     = pin_i ^ cfg_i[GPC_BIT_POL];                                        // [RQ2]
    if (!is_out) begin
      nxt_st.oe_n = 1'b1;
      nxt_st.pin  = 1'b0;
    end else if (cfg_i[GPC_BIT_OTYPE]) begin
      // Open drain: drive only the low level
      nxt_st.oe_n = dval;                                                       // [RQ4]
      nxt_st.pin  = 1'b0;
    end else begin
      nxt_st.oe_n = 1'b0;                                                       // [RQ4]
      nxt_st.pin  = dval;
    end
    nxt_st.gp_in  = cfg_i[GPC_BIT_ALT] ? 1'b0 : rx;                             // [RQ3]
    nxt_st.alt_in = cfg_i[GPC_BIT_ALT] ? rx : 1'b0;                             // [RQ3]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{pin: 1'b0, oe_n: 1'b1, gp_in: 1'b0, alt_in: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_o      = st_ff.pin;
  assign pin_oe_n_o = st_ff.oe_n;
  assign gp_in_o    = st_ff.gp_in;
  assign alt_in_o   = st_ff.alt_in;

  a_input_floats: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cfg_i[GPC_BIT_ALT] && cfg_i[GPC_BIT_DIR]) |=> pin_oe_n_o)  // [RQ1]
    else $error("input pin is driven");
  a_od_no_high: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(cfg_i[GPC_BIT_OTYPE]) && !pin_oe_n_o |-> !pin_o)  // [RQ4]
    else $error("open drain drives high");

endmodule

// *** dv/gpc_pad_model.sv ***
`timescale 1ns/1ps
module gpc_pad_model (
  input  wire logic [9:0] drv_i,
  input  wire logic [9:0] oe_n_i,
  input  wire logic [9:0] ext_val_i,
  input  wire logic [9:0] ext_en_i,
  output logic      [9:0] pad_o
);
  // ----------------------------------------
  // Board pads, pull-up when nobody drives
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (!oe_n_i[i]) begin
        pad_o[i] = drv_i[i];
      end else if (ext_en_i[i]) begin
        pad_o[i] = ext_val_i[i];
      end else begin
        pad_o[i] = 1'b1;
      end
    end
  end
endmodule

// *** dv/gpc_bank_test.sv ***
`timescale 1ns/1ps
module gpc_bank_test;
  import gpc_pkg::*;
  logic        clk_i, rst_i, main_rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [9:0]  adr_i, pin_i, pin_o, pin_oe_n_o, gp_out_i, gp_in_o, ext_val, ext_en;
  logic [3:0]  sel_i, alt_in;
  logic [31:0] dat_i, dat_o;
  logic [5:0]  alt_out;
  logic [31:0] rd;
  logic [9:0]  ao_exp [6] = '{10'h002, 10'h004, 10'h020, 10'h040, 10'h100, 10'h200};
  logic [9:0]  ai_val [4] = '{10'h001, 10'h008, 10'h010, 10'h080};
  logic [3:0]  ai_exp [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  int          error_cnt, samples_checked, cycles;
  logic [7:0]  rst_tab [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h04, 8'h01};
  // Pin 2.5 rows: config, data, expected {pin, oe_n, gp_in}, compare mask
  logic [7:0]  pc_cfg [6] = '{8'h00, 8'h02, 8'h80, 8'h80, 8'h01, 8'h03};
  logic        pc_val [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [2:0]  pc_exp [6] = '{3'b100, 3'b000, 3'b000, 3'b010, 3'b010, 3'b011};
  logic [2:0]  pc_msk [6] = '{3'b110, 3'b110, 3'b110, 3'b110, 3'b011, 3'b011};

  gpc_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .main_rst_i(main_rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .gp_out_i(gp_out_i), .gp_in_o(gp_in_o),
    .music_serial_rx_o(alt_in[3]), .music_serial_tx_i(alt_out[0]), .sys_mgmt_irq_n_i(alt_out[1]),
    .fan_speed_sense_2_o(alt_in[2]), .fan_speed_sense_1_o(alt_in[1]), .fan_drive_2_i(alt_out[2]),
    .fan_drive_1_i(alt_out[3]), .infrared_rx_2_o(alt_in[0]), .infrared_tx_2_i(alt_out[4]),
    .keyboard_reset_n_i(alt_out[5]));
  gpc_pad_model i_pads (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pin_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    {main_rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, gp_out_i, ext_val, ext_en, alt_out} = '0;
    sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    settle();
    chk("oe_n after reset", pin_oe_n_o, 10'h2FF);
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, GPC_IDX_FIRST + 8'(i), 8'h00);
      chk("reset value", rd, rst_tab[i]);
      wb(1'b1, GPC_IDX_FIRST + 8'(i), 8'hFF);
      wb(1'b0, GPC_IDX_FIRST + 8'(i), 8'h00);
      chk("masked write", rd, 8'h87);
    end
    wb(1'b1, 8'h3A, 8'hFF);
    wb(1'b0, 8'h3A, 8'h00);
    chk("unmapped read", rd, 8'h00);
    ext_en <= 10'h3FF;
    for (int i = 0; i < 6; i++) begin
      gp_out_i[0] <= pc_val[i];
      ext_val[0]  <= pc_val[i];
      wb(1'b1, GPC_IDX_P25, pc_cfg[i]);
      settle();
      chk("pin 2.5 pad", {pin_o[0], pin_oe_n_o[0], gp_in_o[0]} & pc_msk[i], pc_exp[i]);
    end
    for (int i = 0; i < 10; i++) wb(1'b1, GPC_IDX_FIRST + 8'(i), 8'h04);
    for (int v = 0; v < 2; v++) begin
      alt_out <= {6{v[0]}};
      ext_val <= {10{v[0]}};
      settle();
      chk("alt drive", pin_o & 10'h366, v[0] ? 10'h366 : 10'h000);
      chk("alt enable", pin_oe_n_o & 10'h366, 10'h000);
      chk("alt inputs", alt_in, {4{v[0]}});
      chk("gpio in off", gp_in_o, 10'h000);
    end
    for (int k = 0; k < 6; k++) begin
      alt_out <= 6'h01 << k;
      if (k < 4) ext_val <= ai_val[k];
      settle();
      chk("alt out map", pin_o & 10'h366, ao_exp[k]);
      if (k < 4) chk("alt in map", alt_in, ai_exp[k]);
    end
    wb(1'b1, GPC_IDX_P36, 8'h06);
    alt_out <= 6'h00;
    settle();
    chk("kbd inverted", pin_o[9], 1'b1);
    sel_i <= 4'hE;
    wb(1'b1, GPC_IDX_P36, 8'h00);
    sel_i <= 4'hF;
    wb(1'b0, GPC_IDX_P36, 8'h00);
    chk("sel0 write ignored", rd, 8'h06);
    wb(1'b1, GPC_IDX_P32, 8'h87);
    wb(1'b1, GPC_IDX_P33, 8'h87);
    wb(1'b1, GPC_IDX_P35, 8'h87);
    wb(1'b1, GPC_IDX_P25, 8'h87);
    main_rst_i <= 1'b1;
    @(posedge clk_i);
    main_rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, GPC_IDX_P32, 8'h00);
    chk("main reset 3.2", rd, 8'h00);
    wb(1'b0, GPC_IDX_P33, 8'h00);
    chk("main reset 3.3", rd, 8'h00);
    wb(1'b0, GPC_IDX_P35, 8'h00);
    chk("main reset 3.5", rd, 8'h04);
    wb(1'b0, GPC_IDX_P25, 8'h00);
    chk("main reset 2.5 kept", rd, 8'h87);
    wb(1'b1, GPC_IDX_P32, 8'h87);
    wb(1'b1, GPC_IDX_RST_CTRL, 8'h00);
    main_rst_i <= 1'b1;
    @(posedge clk_i);
    main_rst_i <= 1'b0;
    wb(1'b0, GPC_IDX_RST_CTRL, 8'h00);
    chk("reload enable", rd, 8'h00);
    wb(1'b0, GPC_IDX_P32, 8'h00);
    chk("reload disabled", rd, 8'h87);
    finish_test();
  end
endmodule
